// [logic/ldss_sequencer.sv]
/*
 * Startup and fault sequencer for a four-channel LED backlight driver.
 * Assumes swTick is a one-cycle pulse per boost switching cycle, and that
 * the host drives the enable pin and keeps a low time to power down.
 */
// Notes on behaviour
// - start needs enable high and lockout cleared
// - low freq_set_sync_pin blocks power-up
// - system fault check before enabling channels
// - disconnect switch on, then check led pins
// - detection starts only after gate ready
// - latch pin status after 3000-4000 switching cycles
// - classify pins shorted, unused or in use
// - unused channel dropped from regulation loop
// - shorted pin holds halt, then rechecks
// - 1-2x overcurrent shuts down after 10000 cycles
// - above 2x overcurrent shuts down within 3us
// - enable low 32750 cycles enters shutdown
// - soft start uses reduced currents, then full
module ldss_sequencer
   import ldss_pkg::*;
#(
   parameter int NCH            = NUM_CH,
   parameter int DIM_OFF_CYCLES = DIM_OFF_SHUT_SW,    // switching cycles
   parameter int SLOW_FAULT_CYC = GATE_FAULT_SLOW_SW, // switching cycles
   parameter int DETECT_CYC     = DETECT_MIN_SW       // switching cycles
) (
   input  wire logic           ref_clk,          // 10 MHz clock
   input  wire logic           rstn,             // async reset, active low
   input  wire logic           swTick,           // switching-clock pulse
   input  wire logic           enableDim,        // enable/dimming pin
   input  wire logic           freq_set_sync_pin,// low blocks power-up
   input  wire logic           supply_lockout,   // high while supply too low
   input  wire logic           gateReadyCmp,     // gate at supply minus offset
   input  wire logic           senseOc1x,        // supply_current_sense above 1x trip
   input  wire logic           senseOc2x,        // supply_current_sense above 2x trip
   input  wire logic [NCH-1:0] ledDetCmp,        // led pin above detect level
   input  wire logic [NCH-1:0] ledShortCmp,      // led pin below short level
   input  wire logic [NCH-1:0] ledUseCmp,        // led pin at in-use level
   input  wire logic [NCH-1:0] ledHighCmp,       // led pin high enough for full
   output logic                disconnectOn,     // input disconnect switch drive
   output logic [NCH-1:0]      led_sink_channel, // channel enabled in regulation
   output logic                soft_start_sink_current, // reduced sink current
   output logic                swLimitReduced,   // reduced switch limit
   output logic                shortHalt,        // halted on shorted pin
   output logic                faultShutdown,    // overcurrent shutdown latched
   output logic                seqRunning        // full regulation reached
);
   ldss_sync_if #(.N(NCH)) syn ();

   // ------------------------------------------------------------
   // comparator synchronisation
   // ------------------------------------------------------------
   ldss_sync #(.N(NCH)) u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .rawIn   ({ledHighCmp, ledUseCmp, ledShortCmp, ledDetCmp,
                 senseOc2x, senseOc1x, gateReadyCmp, ~supply_lockout}),
      .so      (syn.src)
   );

   // ------------------------------------------------------------
   // sequencer state
   // ------------------------------------------------------------
   ldss_state_t         state_r, state_nxt;
   logic [SW_CNT_W-1:0] onCnt_r, onCnt_nxt;     // first-pulse ref clocks
   logic [SW_CNT_W-1:0] detCnt_r, detCnt_nxt;   // detection switching cycles
   logic [SW_CNT_W-1:0] lowCnt_r, lowCnt_nxt;   // enable-low switching cycles
   logic [SW_CNT_W-1:0] ocCnt_r, ocCnt_nxt;     // slow overcurrent cycles
   logic [NCH-1:0]      chan_r, chan_nxt;
   logic                flt_r, flt_nxt;
   logic                startOk, sysOk, anyShort, allDet;

   function automatic logic [SW_CNT_W-1:0] inc(input logic [SW_CNT_W-1:0] v);
      inc = (&v) ? v : v + 16'h0001;
   endfunction

   // start and system-check conditions
   always_comb begin
      startOk  = enableDim && syn.lockoutOk && freq_set_sync_pin &&
                 (onCnt_r >= SW_CNT_W'(FIRST_ON_MIN_CYC));
      sysOk    = syn.lockoutOk && freq_set_sync_pin && !flt_r;
      anyShort = |syn.shortLow;
      allDet   = &(syn.aboveDet | syn.shortLow);
   end

   // next state and counters
   always_comb begin
      state_nxt  = state_r;
      chan_nxt   = chan_r;
      flt_nxt    = flt_r;
      onCnt_nxt  = enableDim ? inc(onCnt_r) : '0;
      detCnt_nxt = detCnt_r;
      lowCnt_nxt = enableDim ? '0 : (swTick ? inc(lowCnt_r) : lowCnt_r);
      ocCnt_nxt  = (syn.ocSlow && !syn.ocFast && disconnectOn) ?
                   (swTick ? inc(ocCnt_r) : ocCnt_r) : '0;
      // long enable low clears the fault; a fault raised in the same cycle wins
      if (lowCnt_r >= SW_CNT_W'(DIM_OFF_CYCLES))
         flt_nxt = 1'b0;
      // overcurrent shutdown
      if (disconnectOn && syn.ocFast)
         flt_nxt = 1'b1;
      if (disconnectOn && ocCnt_r >= SW_CNT_W'(SLOW_FAULT_CYC))
         flt_nxt = 1'b1;
      unique case (state_r)
         LDSS_OFF: begin
            chan_nxt = '0;
            if (startOk && !flt_r)
               state_nxt = LDSS_GATE_WAIT;
         end
         LDSS_GATE_WAIT: begin
            detCnt_nxt = '0;
            if (syn.gateReady)
               state_nxt = LDSS_DETECT;
         end
         LDSS_DETECT: begin
            if (!allDet)
               detCnt_nxt = '0;
            else if (swTick)
               detCnt_nxt = inc(detCnt_r);
            if (detCnt_r >= SW_CNT_W'(DETECT_CYC)) begin
               chan_nxt = syn.inUse & ~syn.shortLow;
               state_nxt = anyShort ? LDSS_HALT : LDSS_SOFT;
            end
         end
         LDSS_HALT: begin
            if (!anyShort) begin
               detCnt_nxt = '0;
               state_nxt  = LDSS_DETECT;
            end
         end
         LDSS_SOFT: begin
            if (syn.ledHigh)
               state_nxt = LDSS_RUN;
         end
         LDSS_RUN: ;
         LDSS_SHUT: begin
            chan_nxt = '0;
         end
         default: state_nxt = LDSS_OFF;
      endcase
      if (state_r != LDSS_OFF && state_r != LDSS_SHUT && (!sysOk || flt_nxt)) begin
         state_nxt = LDSS_SHUT;
         chan_nxt  = '0;
      end
      if (lowCnt_r >= SW_CNT_W'(DIM_OFF_CYCLES)) begin
         state_nxt = LDSS_OFF;
         chan_nxt  = '0;
      end
   end

   // register state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r  <= LDSS_OFF;
         chan_r   <= '0;
         flt_r    <= 1'b0;
         onCnt_r  <= '0;
         detCnt_r <= '0;
         lowCnt_r <= '0;
         ocCnt_r  <= '0;
      end else begin
         state_r  <= state_nxt;
         chan_r   <= chan_nxt;
         flt_r    <= flt_nxt;
         onCnt_r  <= onCnt_nxt;
         detCnt_r <= detCnt_nxt;
         lowCnt_r <= lowCnt_nxt;
         ocCnt_r  <= ocCnt_nxt;
      end
   end

   // outputs from state
   always_comb begin
      disconnectOn            = state_r inside {LDSS_GATE_WAIT, LDSS_DETECT, LDSS_HALT,
                                                LDSS_SOFT, LDSS_RUN};
      led_sink_channel        = (state_r inside {LDSS_SOFT, LDSS_RUN}) ? chan_r : '0;
      soft_start_sink_current = (state_r == LDSS_SOFT);
      swLimitReduced          = (state_r == LDSS_SOFT);
      shortHalt               = (state_r == LDSS_HALT);
      faultShutdown           = flt_r;
      seqRunning              = (state_r == LDSS_RUN);
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence detDone_s;
      state_r == LDSS_DETECT && detCnt_r >= SW_CNT_W'(DETECT_CYC);
   endsequence

   no_start_sync_a: assert property (!freq_set_sync_pin && state_r == LDSS_OFF
      && lowCnt_r < SW_CNT_W'(DIM_OFF_CYCLES) |=> state_r == LDSS_OFF)
      else $error("started with sync pin low");
   gate_wait_a: assert property (state_r == LDSS_GATE_WAIT && !syn.gateReady
      && sysOk && !flt_nxt && lowCnt_r < SW_CNT_W'(DIM_OFF_CYCLES)
      |=> state_r == LDSS_GATE_WAIT)
      else $error("detection began before gate ready");
   detect_latch_a: assert property (detDone_s and (sysOk && !flt_nxt && !anyShort
      && lowCnt_r < SW_CNT_W'(DIM_OFF_CYCLES)) |=> state_r == LDSS_SOFT)
      else $error("detection did not finish");
   short_halt_a: assert property (detDone_s and (anyShort && sysOk && !flt_nxt
      && lowCnt_r < SW_CNT_W'(DIM_OFF_CYCLES)) |=> shortHalt)
      else $error("short did not halt");
   unused_drop_a: assert property (detDone_s |=>
      (chan_r & ($past(syn.shortLow) | ~$past(syn.inUse))) == '0)
      else $error("unused channel enabled");
   fast_oc_a: assert property (disconnectOn && syn.ocFast |=> faultShutdown
      ##1 !disconnectOn)
      else $error("fast overcurrent not shut down");
   slow_oc_a: assert property (ocCnt_r >= SW_CNT_W'(SLOW_FAULT_CYC) && disconnectOn
      |=> faultShutdown)
      else $error("slow overcurrent not shut down");
   dim_off_a: assert property (lowCnt_r >= SW_CNT_W'(DIM_OFF_CYCLES)
      |=> state_r == LDSS_OFF && !disconnectOn)
      else $error("long low enable did not shut down");
   soft_limits_a: assert property (soft_start_sink_current |-> swLimitReduced
      && !seqRunning)
      else $error("soft start levels wrong");
   soft_to_full_a: assert property (soft_start_sink_current && syn.ledHigh && sysOk
      && !flt_nxt && lowCnt_r < SW_CNT_W'(DIM_OFF_CYCLES)
      |=> seqRunning && !swLimitReduced && !soft_start_sink_current)
      else $error("soft start did not go to full levels");
   start_cond_a: assert property ($rose(disconnectOn) |-> $past(startOk))
      else $error("started without enable or lockout");
endmodule

// [logic/ldss_pkg.sv]
/*
 * Constants and state type shared by the LED driver startup sequencer.
 * Assumes a single 10 MHz reference clock and a boost switching-clock tick input.
 */
package ldss_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 100;
   localparam int FIRST_ON_MIN_NS    = 2000;   // first_on_min_time, max figure
   localparam int FIRST_ON_MIN_CYC   =
      (FIRST_ON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GATE_FAULT_FAST_NS = 3000;   // gate_fault_fast_time, longest
   localparam int GATE_FAULT_FAST_CYC =
      (GATE_FAULT_FAST_NS / CLK_PERIOD_NS) < 1 ? 1 : GATE_FAULT_FAST_NS / CLK_PERIOD_NS;
   localparam int DETECT_MIN_SW      = 3000;   // switching cycles before latch
   localparam int DETECT_MAX_SW      = 4000;
   localparam int GATE_FAULT_SLOW_SW = 10000;  // switching cycles at 1-2x trip
   localparam int DIM_OFF_SHUT_SW    = 32750;  // switching cycles of low enable
   localparam int SW_CNT_W           = 16;
   localparam int NUM_CH             = 4;
   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      LDSS_OFF, LDSS_GATE_WAIT, LDSS_DETECT, LDSS_HALT, LDSS_SOFT, LDSS_RUN, LDSS_SHUT
   } ldss_state_t;
endpackage

// [logic/ldss_sync_if.sv]
/*
 * Synchronised comparator results passed from the synchroniser to the sequencer.
 * Assumes both ends run on ref_clk.
 */
interface ldss_sync_if #(parameter int N = 4);
   logic         lockoutOk;   // supply lockout cleared
   logic         gateReady;   // gate at supply minus offset
   logic [N-1:0] aboveDet;    // led pin above detect threshold
   logic [N-1:0] shortLow;    // led pin below short level
   logic [N-1:0] inUse;       // led pin at in-use level
   logic         ocSlow;      // current above 1x trip
   logic         ocFast;      // current above 2x trip
   logic         ledHigh;     // led pins high enough for full current
   modport src (output lockoutOk, gateReady, aboveDet, shortLow, inUse, ocSlow, ocFast, ledHigh);
   modport dst (input  lockoutOk, gateReady, aboveDet, shortLow, inUse, ocSlow, ocFast, ledHigh);
endinterface

// [logic/ldss_sync.sv]
/*
 * Two-flop synchroniser for all analog comparator results.
 * Assumes comparator outputs are asynchronous levels.
 */
module ldss_sync #(
   parameter int N = 4
) (
   input  wire logic         ref_clk,     // system clock
   input  wire logic         rstn,        // async reset, active low
   input  wire logic [4*N+4-1:0] rawIn,   // packed comparator levels
   ldss_sync_if.src          so           // synchronised results
);
   localparam int W = 4*N+4;
   logic [W-1:0] stg1_r, stg1_nxt, stg2_r, stg2_nxt;

   // next values: first stage reads raw, second reads only first
   always_comb begin
      stg1_nxt = rawIn;
      stg2_nxt = stg1_r;
   end

   // register both stages
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stg1_r <= '0;
         stg2_r <= '0;
      end else begin
         stg1_r <= stg1_nxt;
         stg2_r <= stg2_nxt;
      end
   end

   assign so.lockoutOk = stg2_r[0];
   assign so.gateReady = stg2_r[1];
   assign so.ocSlow    = stg2_r[2];
   assign so.ocFast    = stg2_r[3];
   assign so.aboveDet  = stg2_r[4 +: N];
   assign so.shortLow  = stg2_r[4+N +: N];
   assign so.inUse     = stg2_r[4+2*N +: N];
   assign so.ledHigh   = &stg2_r[4+3*N +: N];
endmodule

// [bench/ldss_host_model.sv]
/*
 * Far-side model for the startup sequencer: switching tick, gate and pin comparators.
 * Assumes the bench sets the pin codes and the gate hold just after a ref_clk edge.
 */
module ldss_host_model
   import ldss_pkg::*;
(
   input  wire logic                ref_clk,      // system clock
   input  wire logic                rstn,         // async reset, active low
   input  wire logic                disconnectOn, // switch drive from sequencer
   input  wire logic                softOn,       // soft start flag
   input  wire logic                gateStuck,    // hold gate below ready level
   input  wire logic [2*NUM_CH-1:0] pinLvl,       // per pin: 0 short, 1 unused, 2 in use
   output logic                     swTick,       // one pulse per four clocks
   output logic                     gateReadyCmp, // gate ready comparator
   output logic [NUM_CH-1:0]        ledDetCmp,    // above detect level
   output logic [NUM_CH-1:0]        ledShortCmp,  // below short level
   output logic [NUM_CH-1:0]        ledUseCmp,    // at in-use level
   output logic [NUM_CH-1:0]        ledHighCmp    // high enough for full current
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] tick_r;
   logic [3:0] gate_r;
   logic [2:0] soft_r;
   // ------------------------------------------------------------
   // tick, gate charge and output rise counters
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tick_r <= 2'h0;
         gate_r <= 4'h0;
         soft_r <= 3'h0;
      end else begin
         tick_r <= tick_r + 2'h1;
         gate_r <= !disconnectOn ? 4'h0 : (gate_r == 4'hF ? gate_r : gate_r + 4'h1);
         soft_r <= !softOn ? 3'h0 : (soft_r == 3'h7 ? soft_r : soft_r + 3'h1);
      end
   end
   assign swTick       = (tick_r == 2'h3);
   assign gateReadyCmp = !gateStuck && (gate_r >= 4'h8);
   // pin levels mean nothing until the switch is on
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         ledShortCmp[i] = disconnectOn && (pinLvl[2*i +: 2] == 2'h0);
         ledDetCmp[i]   = disconnectOn && (pinLvl[2*i +: 2] != 2'h0);
         ledUseCmp[i]   = disconnectOn && (pinLvl[2*i +: 2] == 2'h2);
         ledHighCmp[i]  = ledDetCmp[i] && (soft_r == 3'h7);
      end
   end
endmodule

// [bench/led_driver_startup_sequencer_bench.sv]
/*
 * Self-checking bench for the LED driver startup sequencer.
 * Assumes the host model supplies the gate and pin comparators and the switching tick.
 */
module led_driver_startup_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import ldss_pkg::*;
   logic       ref_clk = 1'b0, rstn = 1'b0, enableDim = 1'b0, syncPin = 1'b1;
   logic       lockout = 1'b0, gateStuck = 1'b0, oc1 = 1'b0, oc2 = 1'b0;
   logic       swTick, gateRdy, softOn, swLim, halt, fault, run, discOn;
   logic [7:0] pinLvl = 8'hAA;
   logic [3:0] det, shrt, useLvl, high, chan;
   int         num_errors = 0, n_compared = 0, n;
   // ------------------------------------------------------------
   // clock, design and far side
   // ------------------------------------------------------------
   always #50 ref_clk = ~ref_clk;
   ldss_sequencer #(.DIM_OFF_CYCLES(20), .SLOW_FAULT_CYC(10), .DETECT_CYC(5)) i_dut (
      .ref_clk(ref_clk), .rstn(rstn), .swTick(swTick), .enableDim(enableDim),
      .freq_set_sync_pin(syncPin), .supply_lockout(lockout), .gateReadyCmp(gateRdy),
      .senseOc1x(oc1), .senseOc2x(oc2), .ledDetCmp(det), .ledShortCmp(shrt),
      .ledUseCmp(useLvl), .ledHighCmp(high), .disconnectOn(discOn), .led_sink_channel(chan),
      .soft_start_sink_current(softOn), .swLimitReduced(swLim), .shortHalt(halt),
      .faultShutdown(fault), .seqRunning(run));
   ldss_host_model i_host (
      .ref_clk(ref_clk), .rstn(rstn), .disconnectOn(discOn), .softOn(softOn),
      .gateStuck(gateStuck), .pinLvl(pinLvl), .swTick(swTick), .gateReadyCmp(gateRdy),
      .ledDetCmp(det), .ledShortCmp(shrt), .ledUseCmp(useLvl), .ledHighCmp(high));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   // output selected for a bounded wait
   function automatic logic pick(input int sel);
      case (sel)
         0: return discOn;
         1: return softOn;
         2: return run;
         default: return fault;
      endcase
   endfunction
   task automatic waitLvl(input int sel, input logic lvl, input int lim, output int k);
      k = 0;
      while (pick(sel) !== lvl) begin
         step(1);
         k++;
         if (k > lim) begin
            num_errors++;
            $display("unexpected timeout on output %0d: expected %b", sel, lvl);
            summarize();
         end
      end
   endtask
   task automatic restart();
      rstn = 1'b0;
      enableDim = 1'b0;
      syncPin = 1'b1;
      lockout = 1'b0;
      gateStuck = 1'b0;
      oc1 = 1'b0;
      oc2 = 1'b0;
      pinLvl = 8'hAA;
      step(10);
      rstn = 1'b1;
      chk("outputs after reset", 4'h0, {discOn, softOn, fault, run});
   endtask
   task automatic bring_up();
      enableDim = 1'b1;
      waitLvl(0, 1'b1, 30, n);
      waitLvl(1, 1'b1, 300, n);
      waitLvl(2, 1'b1, 60, n);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_refuse();
      restart();
      enableDim = 1'b1;
      step(15);
      enableDim = 1'b0;
      step(30);
      chk("switch after short pulse", 4'h0, {3'h0, discOn});
      lockout = 1'b1;
      enableDim = 1'b1;
      step(40);
      chk("switch under lockout", 4'h0, {3'h0, discOn});
      lockout = 1'b0;
      syncPin = 1'b0;
      step(40);
      chk("switch with sync pin low", 4'h0, {3'h0, discOn});
      syncPin = 1'b1;
      waitLvl(0, 1'b1, 30, n);
   endtask
   task automatic t_start();
      restart();
      pinLvl = 8'h9A;
      gateStuck = 1'b1;
      enableDim = 1'b1;
      waitLvl(0, 1'b1, 30, n);
      step(120);
      chk("soft start with gate low", 4'h0, {3'h0, softOn});
      gateStuck = 1'b0;
      waitLvl(1, 1'b1, 300, n);
      chk("detect long enough", 4'h1, {3'h0, n >= 20});
      chk("detect short enough", 4'h1, {3'h0, n <= 25});
      chk("channels in soft start", 4'hB, chan);
      chk("reduced limit", 4'h1, {3'h0, swLim});
      waitLvl(2, 1'b1, 60, n);
      chk("channels in run", 4'hB, chan);
      chk("full current", 4'h0, {2'h0, softOn, swLim});
   endtask
   task automatic t_short();
      restart();
      pinLvl = 8'hA2;
      enableDim = 1'b1;
      waitLvl(0, 1'b1, 30, n);
      step(150);
      chk("soft start with shorted pin", 4'h0, {3'h0, softOn});
      chk("halt on shorted pin", 4'h1, {3'h0, halt});
      pinLvl = 8'hAA;
      waitLvl(1, 1'b1, 300, n);
      chk("channels after short removed", 4'hF, chan);
   endtask
   task automatic t_fast();
      restart();
      bring_up();
      oc2 = 1'b1;
      waitLvl(3, 1'b1, 4, n);
      step(1);
      chk("switch after fast fault", 4'h0, {3'h0, discOn});
      chk("channels after fast fault", 4'h0, chan);
      oc2 = 1'b0;
      enableDim = 1'b0;
      step(60);
      chk("fault held while low is short", 4'h1, {3'h0, fault});
      waitLvl(3, 1'b0, 40, n);
   endtask
   task automatic t_slow();
      restart();
      bring_up();
      oc1 = 1'b1;
      step(30);
      chk("slow fault too early", 4'h0, {3'h0, fault});
      waitLvl(3, 1'b1, 20, n);
   endtask
   // sync pin or lockout lost while sequencing opens the switch
   task automatic t_drop();
      restart();
      bring_up();
      syncPin = 1'b0;
      step(2);
      chk("switch after sync pin low", 4'h0, {3'h0, discOn});
      chk("run after sync pin low", 4'h0, {3'h0, run});
      syncPin = 1'b1;
      step(20);
      chk("switch held off after sync", 4'h0, {3'h0, discOn});
      enableDim = 1'b0;
      step(90);
      enableDim = 1'b1;
      waitLvl(0, 1'b1, 30, n);
      lockout = 1'b1;
      step(3);
      chk("switch after lockout", 4'h0, {3'h0, discOn});
   endtask
   initial begin
      t_refuse();
      t_start();
      t_short();
      t_fast();
      t_slow();
      t_drop();
      summarize();
   end
endmodule
